// ### hdl/fxp_pipe.sv
// Four-phase instruction sequencer with overlapped fetch and an 8-bit ALU.
`timescale 1ns/10ps
module fxp_pipe
	import fxp_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	output logic [3:0] phase_o,
	output logic ready_o,
	output logic [10:0] pm_addr_o,
	output logic pm_rd_o,
	input wire logic [14:0] pm_data_i,
	output logic [14:0] exec_instr_o,
	output logic exec_valid_o,
	input wire logic branch_i,
	input wire logic [10:0] branch_target_i,
	input wire logic skip_i,
	input wire logic pc_low_byte_wr_i,
	input wire logic [7:0] pc_low_byte_i,
	input wire logic [3:0] alu_op_i,
	input wire logic [7:0] alu_a_i,
	input wire logic [7:0] alu_b_i,
	output logic [7:0] alu_res_o,
	output logic alu_carry_o
);
	fxp_state_t st;
	fxp_state_t next_st;
	logic run;
	logic at_end;
	logic take_branch;
	logic take_pc_low;
	logic take_skip;
	logic flush;
	logic [10:0] next_fetch;
	logic [8:0] alu_wide;

	assign run = (st.mode == FXP_RUN);
	assign at_end = run && (st.phase == FXP_PH_WRITE);
	// Redirects are honoured only from a real instruction, never from a dummy cycle.
	assign take_branch = at_end && st.instr_valid && branch_i;
	assign take_pc_low = at_end && st.instr_valid && !branch_i && pc_low_byte_wr_i;
	assign take_skip = at_end && st.instr_valid && !branch_i && !pc_low_byte_wr_i && skip_i;
	assign flush = take_branch || take_pc_low || take_skip;

	always_comb
	begin
		if (take_branch)
		begin
			next_fetch = branch_target_i;
		end
		else if (take_pc_low)
		begin
			next_fetch = {st.fetch_addr[10:8], pc_low_byte_i};
		end
		else
		begin
			next_fetch = st.pc;
		end
	end

	always_comb
	begin
		case (alu_op_i)
			FXP_OP_ADD: alu_wide = {1'b0, alu_a_i} + {1'b0, alu_b_i};
			FXP_OP_SUB: alu_wide = {1'b0, alu_a_i} - {1'b0, alu_b_i};
			FXP_OP_AND: alu_wide = {1'b0, alu_a_i & alu_b_i};
			FXP_OP_OR: alu_wide = {1'b0, alu_a_i | alu_b_i};
			FXP_OP_XOR: alu_wide = {1'b0, alu_a_i ^ alu_b_i};
			FXP_OP_RL: alu_wide = {alu_a_i[7], alu_a_i[6:0], alu_a_i[7]};
			FXP_OP_RR: alu_wide = {alu_a_i[0], alu_a_i[0], alu_a_i[7:1]};
			FXP_OP_INC: alu_wide = {1'b0, alu_a_i} + 9'h001;
			FXP_OP_DEC: alu_wide = {1'b0, alu_a_i} - 9'h001;
			FXP_OP_CPL: alu_wide = {1'b0, ~alu_a_i};
			default: alu_wide = {1'b0, alu_a_i};
		endcase
	end

	always_comb
	begin
		next_st = st;
		case (st.mode)
			FXP_HOLD:
			begin
				// Nothing is fetched until the oscillator has had time to settle.
				next_st.startup_cnt = st.startup_cnt + 10'h001;
				if (st.startup_cnt == FXP_STARTUP_LAST)
				begin
					next_st.mode = FXP_RUN;
					next_st.phase = FXP_PH_FETCH;
				end
			end
			FXP_RUN:
			begin
				next_st.phase = st.phase + 2'h1;
				if (st.phase == FXP_PH_FETCH)
				begin
					next_st.prefetch = pm_data_i;
					next_st.pre_valid = 1'b1;
				end
				if (st.phase == FXP_PH_EXEC)
				begin
					next_st.alu_res = alu_wide[7:0];
					next_st.alu_carry = alu_wide[8];
				end
				if (at_end)
				begin
					// Instruction boundary: hand the prefetched word to execution.
					next_st.instr = flush ? FXP_INSTR_NOP : st.prefetch;
					next_st.instr_valid = st.pre_valid && !flush;
					next_st.pre_valid = 1'b0;
					next_st.fetch_addr = next_fetch;
					next_st.pc = next_fetch + FXP_PC_ONE;
				end
			end
			default:
			begin
				next_st.mode = FXP_HOLD;
			end
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			st.mode <= FXP_HOLD;
			st.startup_cnt <= FXP_STARTUP_RESET;
			st.phase <= FXP_PH_FETCH;
			st.pc <= FXP_PC_ONE;
			st.fetch_addr <= FXP_PC_RESET;
			st.prefetch <= FXP_INSTR_NOP;
			st.pre_valid <= 1'b0;
			st.instr <= FXP_INSTR_NOP;
			st.instr_valid <= 1'b0;
			st.alu_res <= 8'h00;
			st.alu_carry <= 1'b0;
		end
		else
		begin
			st <= next_st;
		end
	end

	always_comb
	begin
		phase_o = 4'h0;
		if (run)
		begin
			phase_o[st.phase] = 1'b1;
		end
	end

	assign ready_o = run;
	assign pm_addr_o = st.fetch_addr;
	assign pm_rd_o = run && (st.phase == FXP_PH_FETCH);
	assign exec_instr_o = st.instr;
	assign exec_valid_o = st.instr_valid;
	assign alu_res_o = st.alu_res;
	assign alu_carry_o = st.alu_carry;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_redirect;
		take_branch || take_pc_low || take_skip;
	endsequence

	sequence s_dummy_cycle;
		!exec_valid_o [*4];
	endsequence

	sequence s_fetch_then_last;
		phase_o == 4'h1 ##3 phase_o == 4'h8;
	endsequence

	// The reset check must run while reset is low, so it overrides the default disable.
	property p_reset_clean;
		disable iff (1'b0)
		!rst_n_i |=> phase_o == 4'h0 && !exec_valid_o && exec_instr_o == FXP_INSTR_NOP;
	endproperty

	// Start-up clocks are counted apart from the design's own counter, so a wrong
	// hold length cannot hide behind the very register that sets it.
	logic [9:0] hold_seen;
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			hold_seen <= FXP_STARTUP_RESET;
		end
		else if (!ready_o && hold_seen != FXP_STARTUP_LAST)
		begin
			hold_seen <= hold_seen + 10'h001;
		end
	end

	a_phase_wrap: assert property (at_end |=> phase_o == 4'h1)
		else $error("Phase sequence did not wrap to the fetch phase.");
	a_fetch_only_phase: assert property (pm_rd_o |-> s_fetch_then_last)
		else $error("Fetch strobe outside the fetch phase.");
	a_pc_step: assert property (at_end && !flush |=>
		pm_addr_o == $past(pm_addr_o) + FXP_PC_ONE)
		else $error("Sequential fetch address did not advance by one.");
	a_valid_whole: assert property (run && st.phase == FXP_PH_FETCH |=> $stable(exec_valid_o) [*3])
		else $error("Instruction valid changed inside an instruction cycle.");
	a_redirect_dummy: assert property (s_redirect |=> s_dummy_cycle)
		else $error("Redirect did not insert a dummy cycle.");
	a_branch_target: assert property (take_branch |=> pm_addr_o == $past(branch_target_i))
		else $error("Branch did not fetch from its target.");
	a_pc_low_page: assert property (take_pc_low |=>
		pm_addr_o[10:8] == $past(pm_addr_o[10:8]))
		else $error("Low byte jump left the current page.");
	a_pc_low_byte: assert property (take_pc_low |=> pm_addr_o[7:0] == $past(pc_low_byte_i))
		else $error("Low byte jump used the wrong low byte.");
	a_skip_drop: assert property (take_skip |=> !exec_valid_o ##4
		pm_addr_o == $past(pm_addr_o, 5) + 11'h002)
		else $error("Taken skip did not drop the prefetched word.");
	a_startup_hold: assert property ($rose(ready_o) |-> $past(hold_seen) == FXP_STARTUP_LAST)
		else $error("Execution started before the start-up count.");
	a_startup_late: assert property (!ready_o && hold_seen == FXP_STARTUP_LAST |=> ready_o)
		else $error("Execution did not start after the start-up count.");
	a_hold_no_fetch: assert property (!ready_o |-> !pm_rd_o && !exec_valid_o)
		else $error("Fetch or execution during the start-up hold.");
	a_alu_timing: assert property (run && st.phase != FXP_PH_EXEC |=>
		$stable(alu_res_o) && $stable(alu_carry_o))
		else $error("ALU result changed outside the execute phase.");
	a_reset_clean: assert property (p_reset_clean)
		else $error("Reset left a stale instruction or phase behind.");
endmodule

// ### hdl/fxp_pkg.sv
// Constants and types of the four-phase fetch and execute sequencer.
package fxp_pkg;
	localparam int FXP_PC_W = 11;
	localparam int FXP_INSTR_W = 15;
	localparam int FXP_DATA_W = 8;
	localparam logic [1:0] FXP_PH_FETCH = 2'h0;
	localparam logic [1:0] FXP_PH_DECODE = 2'h1;
	localparam logic [1:0] FXP_PH_EXEC = 2'h2;
	localparam logic [1:0] FXP_PH_WRITE = 2'h3;
	localparam logic [10:0] FXP_PC_RESET = 11'h000;
	localparam logic [10:0] FXP_PC_ONE = 11'h001;
	localparam logic [14:0] FXP_INSTR_NOP = 15'h0000;
	// Start-up hold, counted in system clock periods.
	localparam int FXP_STARTUP_PERIODS = 512;
	localparam int FXP_STARTUP_CYCLES = FXP_STARTUP_PERIODS;
	localparam logic [9:0] FXP_STARTUP_RESET = 10'h000;
	localparam logic [9:0] FXP_STARTUP_LAST = 10'(FXP_STARTUP_CYCLES - 1);
	localparam logic [3:0] FXP_OP_ADD = 4'h0;
	localparam logic [3:0] FXP_OP_SUB = 4'h1;
	localparam logic [3:0] FXP_OP_AND = 4'h2;
	localparam logic [3:0] FXP_OP_OR = 4'h3;
	localparam logic [3:0] FXP_OP_XOR = 4'h4;
	localparam logic [3:0] FXP_OP_RL = 4'h5;
	localparam logic [3:0] FXP_OP_RR = 4'h6;
	localparam logic [3:0] FXP_OP_INC = 4'h7;
	localparam logic [3:0] FXP_OP_DEC = 4'h8;
	localparam logic [3:0] FXP_OP_CPL = 4'h9;

	typedef enum logic {FXP_HOLD, FXP_RUN} fxp_mode_t;

	typedef struct packed {
		fxp_mode_t mode;
		logic [9:0] startup_cnt;
		logic [1:0] phase;
		logic [10:0] pc;
		logic [10:0] fetch_addr;
		logic [14:0] prefetch;
		logic pre_valid;
		logic [14:0] instr;
		logic instr_valid;
		logic [7:0] alu_res;
		logic alu_carry;
	} fxp_state_t;
endpackage

// ### verification/fxp_pmem.sv
// Program memory model answering each fetch with a word derived from its address.
`timescale 1ns/10ps
module fxp_pmem
	import fxp_pkg::*;
(
	input wire logic clk_i,
	input wire logic [10:0] addr_i,
	input wire logic rd_i,
	output logic [14:0] data_o
);
	logic [14:0] last = 15'h0000;
	// Outside a fetch the bus toggles, so a late sample cannot match by luck.
	always_ff @(posedge clk_i)
	begin
		last <= ~data_o;
	end
	assign data_o = rd_i ? {4'h5, addr_i} : last;
endmodule

// ### verification/test_four_phase_fetch_execute_pipeline.sv
// Self-checking bench of the four-phase sequencer.
`timescale 1ns/10ps
module test_four_phase_fetch_execute_pipeline;
	import fxp_pkg::*;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [3:0] phase_o;
	logic [3:0] alu_op_i = 4'h0;
	logic ready_o, pm_rd_o, exec_valid_o, alu_carry_o;
	logic branch_i = 1'b0, skip_i = 1'b0, pc_low_byte_wr_i = 1'b0;
	logic [10:0] pm_addr_o;
	logic [10:0] branch_target_i = 11'h000;
	logic [14:0] pm_data_i, exec_instr_o;
	logic [7:0] pc_low_byte_i = 8'h00, alu_a_i = 8'h00, alu_b_i = 8'h00, alu_res_o;
	int bad_count = 0;
	int check_count = 0;
	fxp_pipe dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .phase_o(phase_o), .ready_o(ready_o),
		.pm_addr_o(pm_addr_o), .pm_rd_o(pm_rd_o), .pm_data_i(pm_data_i),
		.exec_instr_o(exec_instr_o), .exec_valid_o(exec_valid_o), .branch_i(branch_i),
		.branch_target_i(branch_target_i), .skip_i(skip_i), .pc_low_byte_wr_i(pc_low_byte_wr_i),
		.pc_low_byte_i(pc_low_byte_i), .alu_op_i(alu_op_i), .alu_a_i(alu_a_i),
		.alu_b_i(alu_b_i), .alu_res_o(alu_res_o), .alu_carry_o(alu_carry_o));
	fxp_pmem pmem (.clk_i(clk_i), .addr_i(pm_addr_o), .rd_i(pm_rd_o), .data_o(pm_data_i));
	initial
	begin
		forever #10 clk_i = ~clk_i;
	end
	task automatic finish_test();
		$display("Checks %0d, errors %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [14:0] got, input logic [14:0] exp);
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Inputs change on falling edges only, so every rising edge sees settled values.
	task automatic wait_ph(input logic [3:0] p);
		int n;
		n = 0;
		while ((phase_o !== p || exec_valid_o !== 1'b1) && n < 50)
		begin
			@(negedge clk_i);
			n++;
		end
		chk(phase_o, p);
		chk(exec_valid_o, 1'b1);
	endtask
	task automatic t_startup();
		int n;
		n = 0;
		@(negedge clk_i);
		rst_n_i = 1'b1;
		while (ready_o !== 1'b1 && n < 600)
		begin
			chk(phase_o, 4'h0);
			chk(pm_rd_o, 1'b0);
			@(negedge clk_i);
			n++;
		end
		chk(15'(n), 15'(FXP_STARTUP_PERIODS));
		chk(pm_rd_o, 1'b1);
		chk(pm_addr_o, 11'h000);
	endtask
	task automatic t_phases();
		logic [10:0] a;
		a = pm_addr_o;
		for (int i = 0; i < 8; i++)
		begin
			chk(phase_o, 4'h1 << (i % 4));
			chk(pm_rd_o, i % 4 == 0);
			@(negedge clk_i);
		end
		chk(pm_addr_o, a + 11'h002);
		chk(exec_instr_o, {4'h5, a + 11'h001});
		chk(exec_valid_o, 1'b1);
	endtask
	task automatic redir(input logic [10:0] t, input logic [2:0] k, input logic [7:0] lo);
		logic [10:0] a, e;
		wait_ph(4'h8);
		a = pm_addr_o;
		e = k[2] ? t : (k[1] ? {a[10:8], lo} : a + 11'h001);
		{branch_i, pc_low_byte_wr_i, skip_i} = k;
		branch_target_i = t;
		pc_low_byte_i = lo;
		@(negedge clk_i);
		{branch_i, pc_low_byte_wr_i, skip_i} = 3'h0;
		chk(pm_addr_o, e);
		chk(exec_valid_o, 1'b0);
		chk(exec_instr_o, FXP_INSTR_NOP);
		repeat (3) @(negedge clk_i);
		chk(exec_valid_o, 1'b0);
		@(negedge clk_i);
		chk(exec_instr_o, {4'h5, e});
		chk(exec_valid_o, 1'b1);
	endtask
	task automatic t_branch();
		redir(11'h3F0, 3'h4, 8'h00);
		redir(11'h155, 3'h7, 8'hAA);
	endtask
	task automatic t_pc_low();
		redir(11'h000, 3'h2, 8'h12);
	endtask
	task automatic t_skip();
		redir(11'h000, 3'h1, 8'h00);
	endtask
	// Operands go in during the execute phase; the result must then stand a full cycle.
	task automatic alu_case(input logic [3:0] op, input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] r, input logic c);
		wait_ph(4'h4);
		alu_op_i = op;
		alu_a_i = a;
		alu_b_i = b;
		@(negedge clk_i);
		chk(alu_res_o, r);
		chk(alu_carry_o, c);
		alu_a_i = ~a;
		@(negedge clk_i);
		chk(alu_res_o, r);
	endtask
	task automatic t_alu();
		alu_case(FXP_OP_ADD, 8'hF0, 8'h20, 8'h10, 1'b1);
		alu_case(FXP_OP_SUB, 8'h10, 8'h20, 8'hF0, 1'b1);
		alu_case(FXP_OP_AND, 8'hF0, 8'h3C, 8'h30, 1'b0);
		alu_case(FXP_OP_OR, 8'hF0, 8'h0F, 8'hFF, 1'b0);
		alu_case(FXP_OP_XOR, 8'hFF, 8'h0F, 8'hF0, 1'b0);
		alu_case(FXP_OP_RL, 8'h81, 8'h00, 8'h03, 1'b1);
		alu_case(FXP_OP_RR, 8'h81, 8'h00, 8'hC0, 1'b1);
		alu_case(FXP_OP_INC, 8'hFF, 8'h00, 8'h00, 1'b1);
		alu_case(FXP_OP_DEC, 8'h00, 8'h00, 8'hFF, 1'b1);
		alu_case(FXP_OP_CPL, 8'h5A, 8'h00, 8'hA5, 1'b0);
		alu_case(4'hF, 8'h3C, 8'h00, 8'h3C, 1'b0);
	endtask
	task automatic t_reset();
		wait_ph(4'h2);
		rst_n_i = 1'b0;
		@(negedge clk_i);
		chk(phase_o, 4'h0);
		chk(exec_valid_o, 1'b0);
		chk(pm_rd_o, 1'b0);
		chk(ready_o, 1'b0);
		chk(pm_addr_o, FXP_PC_RESET);
		chk(exec_instr_o, FXP_INSTR_NOP);
		chk(alu_res_o, 8'h00);
		t_startup();
		t_phases();
	endtask
	initial
	begin
		repeat (5) @(negedge clk_i);
		t_startup();
		t_phases();
		t_branch();
		t_pc_low();
		t_skip();
		t_alu();
		t_reset();
		finish_test();
	end
	initial
	begin
		#100000;
		bad_count++;
		finish_test();
	end
endmodule
